// *** design/usbsup_pkg.sv ***
package usbsup_pkg;

	// ----------------------------------------------------------------
	// Parameter indexes on the parameter access port
	// ----------------------------------------------------------------
	localparam logic [1:0] IDX_STATION  = 2'h0;
	localparam logic [1:0] IDX_INTERVAL = 2'h1;
	localparam logic [1:0] IDX_SELECT   = 2'h2;

	// ----------------------------------------------------------------
	// Values after reset and setting codes
	// ----------------------------------------------------------------
	localparam logic [15:0] STATION_RESET  = 16'h0000;
	localparam logic [15:0] STATION_MAX    = 16'h001f;
	localparam logic [15:0] INTERVAL_RESET = 16'h270f;
	localparam logic [15:0] INTERVAL_ZERO  = 16'h0000;
	localparam logic [15:0] INTERVAL_MAX   = 16'h270e;
	localparam logic [15:0] INTERVAL_OFF   = 16'h270f;
	localparam logic [15:0] SELECT_RESET   = 16'h270f;
	localparam logic [15:0] SEL_MAKER      = 16'h0002;
	localparam logic [15:0] SEL_USB        = 16'h0003;
	localparam logic [15:0] SEL_PANEL      = 16'h0004;
	localparam logic [15:0] SEL_AUTO       = 16'h270f;

	// ----------------------------------------------------------------
	// Timing: check interval unit is 0.1 s
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 25;
	localparam int CHECK_UNIT_NS     = 100000000;
	localparam int CHECK_UNIT_CYCLES = CHECK_UNIT_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic panel;
		logic usb;
		logic network;
	} usbsup_cmd_src_type;

	typedef struct packed {
		logic        en;
		logic [1:0]  idx;
		logic [15:0] data;
	} usbsup_param_wr_type;

endpackage

// *** design/usbsup_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

module usbsup_timer #(
	parameter int TICK_CYCLES = usbsup_pkg::CHECK_UNIT_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        run,
	input  wire logic        restart,
	input  wire logic [15:0] interval,
	output logic             expired
);

	logic [31:0] prescale_q;
	logic [15:0] elapsed_q;
	logic        tick;

	assign tick = (prescale_q == 32'(TICK_CYCLES - 1));

	// ----------------------------------------------------------------
	// Prescaler to 0.1 s ticks
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale_q <= 32'h0;
		end else if (!run || restart || tick) begin
			prescale_q <= 32'h0;
		end else begin
			prescale_q <= prescale_q + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// Silence time, saturating
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			elapsed_q <= 16'h0;
		end else if (!run || restart) begin
			elapsed_q <= 16'h0;
		end else if (tick && elapsed_q != 16'hffff) begin
			elapsed_q <= elapsed_q + 16'h1;
		end
	end

	// ----------------------------------------------------------------
	// Expiry once silence is longer than the interval
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			expired <= 1'b0;
		end else begin
			expired <= run && !restart && (elapsed_q > interval);
		end
	end

endmodule // usbsup_timer

`default_nettype wire

// *** design/usbsup_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module usbsup_top #(
	parameter int TICK_CYCLES = usbsup_pkg::CHECK_UNIT_CYCLES
) (
	input  wire logic                            ref_clk,
	input  wire logic                            rst_n,
	input  wire logic                            usbAttachPin,
	input  wire logic                            usbExchange,
	input  wire logic                            panelUnitMode,
	input  wire logic                            networkMode,
	input  wire logic                            driveStopped,
	input  wire usbsup_pkg::usbsup_param_wr_type paramWr,
	input  wire logic [1:0]                      paramRdIdx,
	output logic [15:0]                          paramRdData,
	output logic                                 paramWrAck,
	output logic                                 paramWrRefused,
	output usbsup_pkg::usbsup_cmd_src_type       cmdSrc,
	output logic                                 modeIndicatorEn,
	output logic                                 usbParamAccessEn,
	output logic [4:0]                           activeStation,
	output logic                                 usbFault,
	output logic                                 usbLinkUp
);

	// ----------------------------------------------------------------
	// Write check
	// ----------------------------------------------------------------
	function automatic logic writeOk(
		input logic [1:0]  idx,
		input logic [15:0] data,
		input logic        stopped
	);
		logic ok;
		ok = 1'b0;
		unique case (idx)
			usbsup_pkg::IDX_STATION:  ok = (data <= usbsup_pkg::STATION_MAX);
			usbsup_pkg::IDX_INTERVAL: ok = (data <= usbsup_pkg::INTERVAL_OFF);
			usbsup_pkg::IDX_SELECT: begin
				ok = stopped &&
					(data == usbsup_pkg::SEL_MAKER ||
					 data == usbsup_pkg::SEL_USB ||
					 data == usbsup_pkg::SEL_PANEL ||
					 data == usbsup_pkg::SEL_AUTO);
			end
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	logic [15:0] station_q;
	logic [15:0] interval_q;
	logic [15:0] select_q;
	logic [4:0]  activeStation_q;
	logic [15:0] activeInterval_q;
	logic        loadPending_q;
	logic        syncA_q;
	logic        syncB_q;
	logic        syncC_q;
	logic        usbLink_q;
	logic        wrOk;
	logic        usbWins;
	logic        panelWins;
	logic        timeoutRun;
	logic        timeoutHit;
	logic        zeroTrip;
	logic        usbFault_q;
	logic [15:0] rdData_q;
	logic        wrAck_q;
	logic        wrRefused_q;
	usbsup_pkg::usbsup_cmd_src_type src_d;
	usbsup_pkg::usbsup_cmd_src_type src_q;
	logic        indicator_q;
	logic        access_q;

	assign wrOk = writeOk(paramWr.idx, paramWr.data, driveStopped);

	// ----------------------------------------------------------------
	// Parameter storage
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			station_q  <= usbsup_pkg::STATION_RESET;
			interval_q <= usbsup_pkg::INTERVAL_RESET;
			select_q   <= usbsup_pkg::SELECT_RESET;
		end else if (paramWr.en && wrOk) begin
			unique case (paramWr.idx)
				usbsup_pkg::IDX_STATION:  station_q  <= paramWr.data;
				usbsup_pkg::IDX_INTERVAL: interval_q <= paramWr.data;
				usbsup_pkg::IDX_SELECT:   select_q   <= paramWr.data;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Write answer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrAck_q     <= 1'b0;
			wrRefused_q <= 1'b0;
		end else begin
			wrAck_q     <= paramWr.en && wrOk;
			wrRefused_q <= paramWr.en && !wrOk;
		end
	end

	// ----------------------------------------------------------------
	// Settings that act only from the first cycle after reset
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			loadPending_q    <= 1'b1;
			activeStation_q  <= 5'h0;
			activeInterval_q <= usbsup_pkg::INTERVAL_RESET;
		end else if (loadPending_q) begin
			loadPending_q    <= 1'b0;
			activeStation_q  <= station_q[4:0];
			activeInterval_q <= interval_q;
		end
	end

	// ----------------------------------------------------------------
	// Connection detect pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_q   <= 1'b0;
			syncB_q   <= 1'b0;
			syncC_q   <= 1'b0;
			usbLink_q <= 1'b0;
		end else begin
			syncA_q <= usbAttachPin;
			syncB_q <= syncA_q;
			syncC_q <= syncB_q;
			if (syncB_q == syncC_q) begin
				usbLink_q <= syncC_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Command source selection
	// ----------------------------------------------------------------
	assign usbWins = (select_q == usbsup_pkg::SEL_USB) ||
		(select_q == usbsup_pkg::SEL_AUTO && usbLink_q);
	assign panelWins = (select_q == usbsup_pkg::SEL_PANEL) ||
		(select_q == usbsup_pkg::SEL_AUTO && !usbLink_q);

	always_comb begin
		src_d.usb     = panelUnitMode && usbWins;
		src_d.panel   = panelUnitMode && panelWins;
		src_d.network = networkMode;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_q       <= '0;
			indicator_q <= 1'b0;
			access_q    <= 1'b0;
		end else begin
			src_q       <= src_d;
			indicator_q <= panelWins;
			access_q    <= panelUnitMode &&
				(select_q == usbsup_pkg::SEL_AUTO ||
				 select_q == usbsup_pkg::SEL_USB);
		end
	end

	// ----------------------------------------------------------------
	// Communication check
	// ----------------------------------------------------------------
	assign timeoutRun = !loadPending_q && usbLink_q &&
		activeInterval_q != usbsup_pkg::INTERVAL_ZERO &&
		activeInterval_q <= usbsup_pkg::INTERVAL_MAX;
	assign zeroTrip = !loadPending_q && panelUnitMode &&
		activeInterval_q == usbsup_pkg::INTERVAL_ZERO;

	usbsup_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.run      (timeoutRun),
		.restart  (usbExchange),
		.interval (activeInterval_q),
		.expired  (timeoutHit)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			usbFault_q <= 1'b0;
		end else if (zeroTrip || timeoutHit) begin
			usbFault_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Parameter read back
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_q <= 16'h0;
		end else begin
			unique case (paramRdIdx)
				usbsup_pkg::IDX_STATION:  rdData_q <= station_q;
				usbsup_pkg::IDX_INTERVAL: rdData_q <= interval_q;
				usbsup_pkg::IDX_SELECT:   rdData_q <= select_q;
				default:                  rdData_q <= 16'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign paramRdData      = rdData_q;
	assign paramWrAck       = wrAck_q;
	assign paramWrRefused   = wrRefused_q;
	assign cmdSrc           = src_q;
	assign modeIndicatorEn  = indicator_q;
	assign usbParamAccessEn = access_q;
	assign activeStation    = activeStation_q;
	assign usbFault         = usbFault_q;
	assign usbLinkUp        = usbLink_q;

endmodule // usbsup_top

`default_nettype wire

// *** sim/usbsup_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module usbsup_checker #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic                            ref_clk,
	input wire logic                            rst_n,
	input wire logic                            usbAttachPin,
	input wire logic                            usbExchange,
	input wire logic                            panelUnitMode,
	input wire logic                            networkMode,
	input wire logic                            driveStopped,
	input wire usbsup_pkg::usbsup_param_wr_type paramWr,
	input wire logic [1:0]                      paramRdIdx,
	input wire logic [15:0]                     paramRdData,
	input wire logic                            paramWrAck,
	input wire logic                            paramWrRefused,
	input wire usbsup_pkg::usbsup_cmd_src_type  cmdSrc,
	input wire logic                            modeIndicatorEn,
	input wire logic                            usbParamAccessEn,
	input wire logic [4:0]                      activeStation,
	input wire logic                            usbFault,
	input wire logic                            usbLinkUp
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	logic [1:0] up_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) up_q <= 2'h0;
		else if (up_q != 2'h2) up_q <= up_q + 2'h1;
	end
	property p_wr_answer;
		paramWr.en |=> paramWrAck != paramWrRefused;
	endproperty
	property p_idle_quiet;
		!paramWr.en |=> !paramWrAck && !paramWrRefused;
	endproperty
	property p_station_range;
		paramWr.en && paramWr.idx == usbsup_pkg::IDX_STATION &&
		paramWr.data > usbsup_pkg::STATION_MAX |=> paramWrRefused;
	endproperty
	property p_interval_range;
		paramWr.en && paramWr.idx == usbsup_pkg::IDX_INTERVAL &&
		paramWr.data > usbsup_pkg::INTERVAL_OFF |=> paramWrRefused;
	endproperty
	property p_sel_running;
		paramWr.en && paramWr.idx == usbsup_pkg::IDX_SELECT &&
		!driveStopped |=> paramWrRefused;
	endproperty
	property p_ind_dark;
		cmdSrc.usb |-> !modeIndicatorEn;
	endproperty
	property p_one_local;
		!(cmdSrc.usb && cmdSrc.panel);
	endproperty
	property p_net_src;
		$past(rst_n) |-> cmdSrc.network == $past(networkMode);
	endproperty
	property p_access;
		usbParamAccessEn && $past(rst_n) |-> $past(panelUnitMode);
	endproperty
	property p_station_hold;
		up_q == 2'h2 |-> $stable(activeStation);
	endproperty
	property p_link_up;
		usbAttachPin [*6] |-> usbLinkUp;
	endproperty
	property p_link_down;
		!usbAttachPin [*6] |-> !usbLinkUp;
	endproperty
	property p_fault_sticky;
		usbFault |=> usbFault;
	endproperty
	property p_ind_panel;
		cmdSrc.panel |-> modeIndicatorEn;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("no answer");
	a_idle_quiet: assert property (p_idle_quiet) else $error("stray ack");
	a_station_range: assert property (p_station_range) else $error("st");
	a_interval_range: assert property (p_interval_range) else $error("iv");
	a_sel_running: assert property (p_sel_running) else $error("run");
	a_ind_dark: assert property (p_ind_dark) else $error("indicator");
	a_one_local: assert property (p_one_local) else $error("two src");
	a_net_src: assert property (p_net_src) else $error("network");
	a_access: assert property (p_access) else $error("access");
	a_station_hold: assert property (p_station_hold) else $error("stn");
	a_link_up: assert property (p_link_up) else $error("link");
	a_link_down: assert property (p_link_down) else $error("unlink");
	a_fault_sticky: assert property (p_fault_sticky) else $error("fault");
	a_ind_panel: assert property (p_ind_panel) else $error("ind");
	c_panel: cover property (cmdSrc.panel);
	c_ack: cover property (paramWrAck);
	c_refused: cover property (paramWrRefused);
	c_usb: cover property (cmdSrc.usb);
endmodule // usbsup_checker

`default_nettype wire

// *** sim/usbsup_pc_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module usbsup_pc_model (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       plug,
	input  wire logic [3:0] gap,
	output logic            usbAttachPin,
	output logic            usbExchange
);
	// ----------------------------------------------------------------
	// Host exchanges every gap+1 cycles while plugged; gap 0 is silent
	// ----------------------------------------------------------------
	logic [3:0] cnt_q;
	assign usbAttachPin = plug;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q       <= 4'h0;
			usbExchange <= 1'b0;
		end else begin
			cnt_q       <= (cnt_q >= gap) ? 4'h0 : cnt_q + 4'h1;
			usbExchange <= plug && gap != 4'h0 && cnt_q >= gap;
		end
	end
endmodule // usbsup_pc_model

`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic ref_clk, rst_n, plug, usbAttachPin, usbExchange, panelUnitMode;
	logic networkMode, driveStopped, paramWrAck, paramWrRefused;
	logic modeIndicatorEn, usbParamAccessEn, usbFault, usbLinkUp;
	logic rdReq, stReq;
	logic [3:0]                      gap;
	usbsup_pkg::usbsup_param_wr_type paramWr;
	usbsup_pkg::usbsup_cmd_src_type  cmdSrc;
	logic [1:0]                      paramRdIdx;
	logic [15:0]                     paramRdData;
	logic [4:0]                      activeStation;
	logic [31:0]                     rnd;
	int                              num_errors;
	int                              total_checks;
	logic [1:0]                      wrQ [$];
	logic [15:0]                     rdQ [$];
	logic [10:0]                     stQ [$];
	logic [15:0]                     sels [3] = '{16'h3, 16'h4, 16'h270f};

	usbsup_top #(.TICK_CYCLES(4)) i_usbsup_top (.ref_clk, .rst_n,
		.usbAttachPin, .usbExchange, .panelUnitMode, .networkMode,
		.driveStopped, .paramWr, .paramRdIdx, .paramRdData, .paramWrAck,
		.paramWrRefused, .cmdSrc, .modeIndicatorEn, .usbParamAccessEn,
		.activeStation, .usbFault, .usbLinkUp);
	usbsup_pc_model i_usbsup_pc_model (.ref_clk, .rst_n, .plug, .gap,
		.usbAttachPin, .usbExchange);

	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic logic [10:0] ex(input logic [15:0] s,
		input logic l, p, n);
		logic au, pn;
		au = s == 16'h270f;
		pn = s == 16'h0004 | au & !l;
		return {p & pn, p & (s == 16'h0003 | au & l), n, pn,
			p & (s == 16'h0003 | au), 1'b0, 5'h00};
	endfunction

	// ----------------------------------------------------------------
	// Compare and drive
	// ----------------------------------------------------------------
	task automatic cmp(input string n, input logic [15:0] e, s);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic cmp_wr(input logic [1:0] e);
		cmp("wr", {14'h0, e}, {14'h0, paramWrAck, paramWrRefused});
	endtask
	task automatic cmp_rd(input logic [15:0] e);
		cmp("rd", e, paramRdData);
	endtask
	task automatic cmp_st(input logic [10:0] e);
		cmp("st", {5'h0, e}, {5'h0, cmdSrc, modeIndicatorEn,
			usbParamAccessEn, usbFault, activeStation});
	endtask
	task automatic wr(input logic [1:0] i, input logic [15:0] d, e);
		paramWr <= '{1'b1, i, d};
		wrQ.push_back(e[1:0]);
		@(posedge ref_clk);
		paramWr.en <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [1:0] i, input logic [15:0] e);
		paramRdIdx <= i;
		@(posedge ref_clk);
		rdReq <= 1'b1;
		rdQ.push_back(e);
		@(posedge ref_clk);
		rdReq <= 1'b0;
	endtask
	task automatic st(input logic [10:0] e);
		repeat (8) @(posedge ref_clk);
		stReq <= 1'b1;
		stQ.push_back(e);
		@(posedge ref_clk);
		stReq <= 1'b0;
	endtask
	task automatic give_verdict();
		cmp("left", 16'h0, 16'(wrQ.size() + rdQ.size() + stQ.size()));
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		if (paramWrAck | paramWrRefused) cmp_wr(wrQ.pop_front());
		if (rdReq) cmp_rd(rdQ.pop_front());
		if (stReq) cmp_st(stQ.pop_front());
	end

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		num_errors++;
		give_verdict();
	end
	initial begin
		{rst_n, plug, gap, networkMode, rdReq, stReq, paramRdIdx} = '0;
		{panelUnitMode, driveStopped, paramWr, num_errors} = '0;
		total_checks = 0;
		panelUnitMode = 1'b1;
		driveStopped = 1'b1;
		rnd = 32'd89208;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(usbsup_pkg::IDX_STATION, 16'h0000);
		rd(usbsup_pkg::IDX_INTERVAL, 16'h270f);
		rd(usbsup_pkg::IDX_SELECT, 16'h270f);
		rd(2'h3, 16'h0000);
		rnd = xs(rnd);
		wr(usbsup_pkg::IDX_STATION, {11'h0, rnd[4:0]}, 2'h2);
		wr(usbsup_pkg::IDX_STATION, 16'h001f, 2'h2);
		wr(usbsup_pkg::IDX_STATION, 16'h0020, 2'h1);
		rd(usbsup_pkg::IDX_STATION, 16'h001f);
		wr(usbsup_pkg::IDX_INTERVAL, 16'h2710, 2'h1);
		wr(usbsup_pkg::IDX_INTERVAL, 16'h0000, 2'h2);
		rd(usbsup_pkg::IDX_INTERVAL, 16'h0000);
		wr(2'h3, 16'h0000, 2'h1);
		driveStopped <= 1'b0;
		wr(usbsup_pkg::IDX_SELECT, 16'h0004, 2'h1);
		driveStopped <= 1'b1;
		wr(usbsup_pkg::IDX_SELECT, 16'h0005, 2'h1);
		rd(usbsup_pkg::IDX_SELECT, 16'h270f);
		foreach (sels[j]) begin
			wr(usbsup_pkg::IDX_SELECT, sels[j], 2'h2); // always 2
			for (int k = 0; k < 4; k++) begin
				rnd = xs(rnd);
				gap <= rnd[3:0];
				plug <= k[0];
				panelUnitMode <= ~k[1];
				networkMode <= k[1];
				st(ex(sels[j], k[0], ~k[1], k[1]));
			end
		end
		plug <= 1'b1;
		gap <= 4'h0;
		panelUnitMode <= 1'b1;
		networkMode <= 1'b0;
		repeat (200) @(posedge ref_clk);
		st(ex(16'h270f, 1'b1, 1'b1, 1'b0));
		@(posedge ref_clk);
		give_verdict();
	end
endmodule // tb

bind usbsup_top usbsup_checker #(.TICK_CYCLES(TICK_CYCLES)) i_usbsup_checker (
	.ref_clk, .rst_n, .usbAttachPin, .usbExchange, .panelUnitMode,
	.networkMode, .driveStopped, .paramWr, .paramRdIdx, .paramRdData,
	.paramWrAck, .paramWrRefused, .cmdSrc, .modeIndicatorEn,
	.usbParamAccessEn, .activeStation, .usbFault, .usbLinkUp);

`default_nettype wire
